/* File: rtl/flash_bus_cycle.sv */
// one flash bus cycle engine: read or write with timed strobes
`default_nettype none
module flash_bus_cycle
    import flash_poll_pkg::*;
#(
    parameter int pulse_cycles = strobe_cycles
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // request
    input wire logic start,
    input wire logic write,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    output logic done,
    output logic [15:0] rdata,
    // flash pins
    output logic [19:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    logic [7:0] cnt_ff;
    logic busy_ff;
    wire last_w = (cnt_ff == 8'(pulse_cycles - 1));
    // ***************************
    // strobe timing
    // ***************************
    always_ff @(posedge sys_clk)
    begin
        done <= 1'b0;
        if (sys_rst)
        begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h00;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            flash_addr <= 20'h00000;
            flash_dq_out <= 16'h0000;
            rdata <= 16'h0000;
        end
        else if (!busy_ff && start)
        begin
            busy_ff <= 1'b1;
            cnt_ff <= 8'h00;
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe <= write;
            flash_ce_n <= 1'b0;
            flash_oe_n <= write;
            flash_we_n <= !write;
        end
        else if (busy_ff)
        begin
            cnt_ff <= cnt_ff + 8'h01;
            if (last_w)
            begin
                // one cycle per chip enable, so every read advances toggles
                busy_ff <= 1'b0;
                done <= 1'b1;
                rdata <= flash_dq_in;
                flash_ce_n <= 1'b1;
                flash_oe_n <= 1'b1;
                flash_we_n <= 1'b1;
                flash_dq_oe <= 1'b0;
            end
        end
    end
endmodule : flash_bus_cycle
`default_nettype wire

/* File: rtl/flash_poll_pkg.sv */
// constants shared by the flash status polling controller
`default_nettype none
package flash_poll_pkg;
    // register byte offsets of the controller's own register file
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] stat_off = 8'h04;
    localparam logic [7:0] addr_off = 8'h08;
    localparam logic [7:0] data_off = 8'h0C;
    localparam logic [7:0] rdat_off = 8'h10;
    // ctrl register fields (write 1 to start)
    localparam int ctrl_poll_bit = 0;
    localparam int ctrl_erase_bit = 1;
    localparam int ctrl_reset_bit = 2;
    // data bus bit positions of the status bits
    localparam int completion_poll_pos = 7;
    localparam int toggle_status_pos = 6;
    localparam int timeout_failure_pos = 5;
    localparam int erase_window_pos = 3;
    localparam int sector_toggle_pos = 2;
    // flash commands
    localparam logic [7:0] cmd_reset = 8'hF0;
    localparam logic [7:0] cmd_unlock1 = 8'hAA;
    localparam logic [7:0] cmd_unlock2 = 8'h55;
    localparam logic [7:0] cmd_erase_setup = 8'h80;
    localparam logic [7:0] cmd_sector_erase = 8'h30;
    localparam logic [19:0] unlock_addr1 = 20'h00555;
    localparam logic [19:0] unlock_addr2 = 20'h002AA;
    // timing
    localparam int clk_mhz = 20;
    localparam int strobe_ns = 100;
    localparam int strobe_cycles = (strobe_ns * clk_mhz + 999) / 1000;
    localparam int erase_gap_us = 50;
    localparam int erase_gap_cycles = erase_gap_us * clk_mhz;
    // result codes in status register
    localparam logic [1:0] res_none = 2'h0;
    localparam logic [1:0] res_done = 2'h1;
    localparam logic [1:0] res_fail = 2'h2;
    localparam logic [1:0] res_rejected = 2'h3;
    typedef enum logic [5:0] {
        st_idle = 6'b000001,
        st_cycle = 6'b000010,
        st_first = 6'b000100,
        st_compare = 6'b001000,
        st_recheck = 6'b010000,
        st_finish = 6'b100000
    } poll_state_t;
endpackage : flash_poll_pkg
`default_nettype wire

/* File: rtl/flash_status_poller.sv */
// host controller polling flash write status over its bus pins
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`default_nettype none
module flash_status_poller
    import flash_poll_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // flash pins
    output logic [19:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    input wire logic ready_busy_n_output
);
    // ***************************
    // bus slave
    // ***************************
    logic ph_wr_ff;
    logic [7:0] ph_addr_ff;
    logic [19:0] addr_reg_ff;
    logic [15:0] data_reg_ff;
    logic [15:0] rdat_ff;
    logic [1:0] result_ff;
    logic [15:0] first_ff;
    logic window_ff;
    logic [3:0] cmd_idx_ff;
    logic cmd_mode_ff;
    poll_state_t state_ff;
    wire addr_ph_w = hsel && hready && htrans[1];
    wire wr_ctrl_w = ph_wr_ff && (ph_addr_ff == ctrl_off);
    wire busy_w = (state_ff != st_idle);
    wire go_poll_w = wr_ctrl_w && hwdata[ctrl_poll_bit] && !busy_w;
    wire go_erase_w = wr_ctrl_w && hwdata[ctrl_erase_bit] && !busy_w;
    wire go_reset_w = wr_ctrl_w && hwdata[ctrl_reset_bit] && !busy_w;
    // device busy pin reflects running algorithm
    wire [31:0] stat_w = {24'h000000, window_ff, rdat_ff[sector_toggle_pos],
        rdat_ff[timeout_failure_pos], !ready_busy_n_output, result_ff, busy_w, 1'b0};
    wire [31:0] rd_mux_w = (haddr == stat_off) ? stat_w :
                           (haddr == addr_off) ? {12'h000, addr_reg_ff} :
                           (haddr == data_off) ? {16'h0000, data_reg_ff} :
                           (haddr == rdat_off) ? {16'h0000, rdat_ff} : 32'h00000000;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ph_wr_ff <= 1'b0;
            ph_addr_ff <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            addr_reg_ff <= 20'h00000;
            data_reg_ff <= 16'h0000;
        end
        else
        begin
            ph_wr_ff <= addr_ph_w && hwrite;
            ph_addr_ff <= haddr;
            if (addr_ph_w && !hwrite)
                hrdata <= rd_mux_w;
            if (ph_wr_ff && ph_addr_ff == addr_off)
                addr_reg_ff <= hwdata[19:0];
            if (ph_wr_ff && ph_addr_ff == data_off)
                data_reg_ff <= hwdata[15:0];
        end
    end
    // ***************************
    // flash bus cycles
    // ***************************
    logic cyc_start_ff;
    logic cyc_write_ff;
    logic [19:0] cyc_addr_ff;
    logic [15:0] cyc_wdata_ff;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    flash_bus_cycle u_cycle (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(cyc_start_ff),
        .write(cyc_write_ff),
        .addr(cyc_addr_ff),
        .wdata(cyc_wdata_ff),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n)
    );
    // ***************************
    // command and polling sequencer
    // ***************************
    // sector erase sequence: six writes, last carries the sector address
    wire [19:0] seq_addr_w = (cmd_idx_ff == 4'h0 || cmd_idx_ff == 4'h3) ? unlock_addr1 :
                             (cmd_idx_ff == 4'h1 || cmd_idx_ff == 4'h4) ? unlock_addr2 :
                             (cmd_idx_ff == 4'h2) ? unlock_addr1 : addr_reg_ff;
    wire [7:0] seq_data_w = (cmd_idx_ff == 4'h0 || cmd_idx_ff == 4'h3) ? cmd_unlock1 :
                            (cmd_idx_ff == 4'h1 || cmd_idx_ff == 4'h4) ? cmd_unlock2 :
                            (cmd_idx_ff == 4'h2) ? cmd_erase_setup : cmd_sector_erase;
    wire seq_last_w = (cmd_idx_ff == 4'h5);
    // toggle compare on the toggle status bit (bit 6) of the two reads only
    wire toggling_w = (first_ff[toggle_status_pos] != cyc_rdata[toggle_status_pos]);
    wire timeout_w = cyc_rdata[timeout_failure_pos];
    always_ff @(posedge sys_clk)
    begin
        cyc_start_ff <= 1'b0;
        if (sys_rst)
        begin
            state_ff <= st_idle;
            result_ff <= res_none;
            first_ff <= 16'h0000;
            rdat_ff <= 16'h0000;
            window_ff <= 1'b0;
            cmd_idx_ff <= 4'h0;
            cmd_mode_ff <= 1'b0;
            cyc_write_ff <= 1'b0;
            cyc_addr_ff <= 20'h00000;
            cyc_wdata_ff <= 16'h0000;
        end
        else
        begin
            unique case (state_ff)
                st_idle:
                begin
                    if (go_erase_w)
                    begin
                        // extra sector only while the window is open
                        cmd_mode_ff <= 1'b1;
                        cmd_idx_ff <= 4'h0;
                        result_ff <= res_none;
                        state_ff <= st_cycle;
                        cyc_start_ff <= 1'b1;
                        cyc_write_ff <= 1'b1;
                        cyc_addr_ff <= unlock_addr1;
                        cyc_wdata_ff <= {8'h00, cmd_unlock1};
                    end
                    else if (go_reset_w)
                    begin
                        cmd_mode_ff <= 1'b0;
                        state_ff <= st_finish;
                        cyc_start_ff <= 1'b1;
                        cyc_write_ff <= 1'b1;
                        cyc_wdata_ff <= {8'h00, cmd_reset};
                    end
                    else if (go_poll_w)
                    begin
                        // always restart from the first of two reads
                        result_ff <= res_none;
                        state_ff <= st_first;
                        cyc_start_ff <= 1'b1;
                        cyc_write_ff <= 1'b0;
                        cyc_addr_ff <= addr_reg_ff;
                    end
                end
                st_cycle:
                begin
                    if (cyc_done)
                    begin
                        if (seq_last_w)
                        begin
                            // check window after the command
                            state_ff <= st_finish;
                            cyc_start_ff <= 1'b1;
                            cyc_write_ff <= 1'b0;
                            cyc_addr_ff <= addr_reg_ff;
                        end
                        else
                        begin
                            cmd_idx_ff <= cmd_idx_ff + 4'h1;
                            state_ff <= st_cycle;
                            cyc_start_ff <= 1'b1;
                            cyc_write_ff <= 1'b1;
                        end
                    end
                end
                st_first:
                begin
                    if (cyc_done)
                    begin
                        first_ff <= cyc_rdata;
                        state_ff <= st_compare;
                        cyc_start_ff <= 1'b1;
                    end
                end
                st_compare:
                begin
                    if (cyc_done)
                    begin
                        rdat_ff <= cyc_rdata;
                        window_ff <= cyc_rdata[erase_window_pos];
                        if (!toggling_w)
                        begin
                            result_ff <= res_done;
                            state_ff <= st_idle;
                        end
                        else if (timeout_w)
                        begin
                            // toggle may stop as timeout rises: recheck
                            first_ff <= cyc_rdata;
                            state_ff <= st_recheck;
                            cyc_start_ff <= 1'b1;
                        end
                        else
                        begin
                            // keep polling; a fresh pair of reads
                            state_ff <= st_first;
                            cyc_start_ff <= 1'b1;
                        end
                    end
                end
                st_recheck:
                begin
                    if (cyc_done)
                    begin
                        rdat_ff <= cyc_rdata;
                        if (!toggling_w)
                        begin
                            result_ff <= res_done;
                            state_ff <= st_idle;
                        end
                        else
                        begin
                            // failed: reset command back to array reads
                            result_ff <= res_fail;
                            cmd_mode_ff <= 1'b0;
                            state_ff <= st_finish;
                            cyc_start_ff <= 1'b1;
                            cyc_write_ff <= 1'b1;
                            cyc_wdata_ff <= {8'h00, cmd_reset};
                        end
                    end
                end
                st_finish:
                begin
                    if (cyc_done)
                    begin
                        if (cmd_mode_ff)
                        begin
                            window_ff <= cyc_rdata[erase_window_pos];
                            rdat_ff <= cyc_rdata;
                            // window already closed: sector may be refused
                            result_ff <= cyc_rdata[erase_window_pos] ? res_rejected : res_done;
                        end
                        state_ff <= st_idle;
                    end
                end
                default:
                    state_ff <= st_idle;
            endcase
            if (state_ff == st_cycle && cyc_done && !seq_last_w)
            begin
                cyc_addr_ff <= (cmd_idx_ff == 4'h4) ? addr_reg_ff : seq_addr_w_next(cmd_idx_ff);
                cyc_wdata_ff <= {8'h00, seq_data_next(cmd_idx_ff)};
            end
        end
    end
    function automatic logic [19:0] seq_addr_w_next(input logic [3:0] idx);
        seq_addr_w_next = (idx == 4'h0 || idx == 4'h3) ? unlock_addr2 : unlock_addr1;
    endfunction : seq_addr_w_next
    function automatic logic [7:0] seq_data_next(input logic [3:0] idx);
        seq_data_next = (idx == 4'h0 || idx == 4'h3) ? cmd_unlock2 :
                        (idx == 4'h1) ? cmd_erase_setup :
                        (idx == 4'h4) ? cmd_sector_erase : cmd_unlock1;
    endfunction : seq_data_next
    // chip erase is never issued here, so no window check for it
    wire unused_w = ^{seq_addr_w, seq_data_w, hsize, hwdata[31:20]};
endmodule : flash_status_poller
`default_nettype wire

/* File: test/flash_dev_model.sv */
// behavioural flash device answering status reads and commands
`default_nettype none
module flash_dev_model
    import flash_poll_pkg::*;
#(
    parameter int win_cycles = 300,
    parameter logic [15:0] array_word = 16'h1289
)(
    // clock
    input wire logic sys_clk,
    // flash pins
    input wire logic [19:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    output logic [15:0] dq_wire,
    output logic rb_low,
    // scenario control
    input wire logic kick,
    input wire logic [7:0] busy_reads,
    input wire logic fail_mode,
    output logic [7:0] resets_seen,
    output logic [7:0] erases_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rem = 8'h00;
    logic [7:0] n_rst = 8'h00;
    logic [7:0] n_ers = 8'h00;
    logic t6 = 1'b0;
    logic t2 = 1'b0;
    logic fail_ff = 1'b0;
    logic ers = 1'b0;
    logic wr_q = 1'b0;
    logic ce_q = 1'b1;
    logic [2:0] seq = 3'h0;
    logic [19:0] a_q = 20'h00000;
    logic [19:0] sec = 20'h00000;
    logic [15:0] d_q = 16'h0000;
    logic [15:0] last = 16'h0000;
    int wcnt = 0;
    wire logic run = (rem != 8'h00) || fail_ff;
    wire logic act = run || (wcnt != 0);
    wire logic [15:0] stat = {8'h00, 1'b0, t6, fail_ff, 1'b0, wcnt == 0, t2, 2'b00};
    wire logic second = (seq == 3'h1) || (seq == 3'h4);
    wire logic [7:0] exp_d = second ? cmd_unlock2 : (seq == 3'h2) ? cmd_erase_setup :
        (seq == 3'h5) ? cmd_sector_erase : cmd_unlock1;
    wire logic hit = (d_q[7:0] == exp_d) && (seq == 3'h5 || a_q == (second ? unlock_addr2 : unlock_addr1));
    wire logic ends = flash_ce_n && !ce_q;
    assign resets_seen = n_rst;
    assign erases_seen = n_ers;
    assign rb_low = run;
    // released data lines wander so a stale value is never mistaken for data
    assign dq_wire = (!flash_ce_n && !flash_oe_n) ? (act ? stat : array_word) :
        flash_dq_oe ? flash_dq_out : ~last;
    always @(posedge sys_clk)
    begin
        last <= dq_wire;
        ce_q <= flash_ce_n;
        if (!flash_ce_n)
        begin
            wr_q <= !flash_we_n;
            a_q <= flash_addr;
            d_q <= flash_dq_out;
        end
        if (wcnt == 1)
            rem <= busy_reads;
        if (wcnt != 0)
            wcnt <= wcnt - 1;
        if (kick)
        begin
            rem <= busy_reads;
            fail_ff <= fail_mode;
        end
        if (ends && wr_q && !(ers && wcnt == 0 && run))
        begin
            if (d_q[7:0] == cmd_reset)
            begin
                seq <= 3'h0;
                fail_ff <= 1'b0;
                rem <= 8'h00;
                n_rst <= n_rst + 8'h01;
            end
            else if (!hit)
                seq <= 3'h0;
            else if (seq == 3'h5)
            begin
                seq <= 3'h0;
                ers <= 1'b1;
                sec <= a_q;
                wcnt <= win_cycles;
                n_ers <= n_ers + 8'h01;
            end
            else
                seq <= seq + 3'h1;
        end
        if (ends && !wr_q && act)
        begin
            t6 <= ~t6;
            if (ers && a_q[19:12] == sec[19:12])
                t2 <= ~t2;
            if (rem != 8'h00)
                rem <= rem - 8'h01;
            if (rem == 8'h01 && wcnt == 0)
                ers <= 1'b0;
        end
    end
endmodule : flash_dev_model
`default_nettype wire

/* File: test/flash_status_poller_sva.sv */
// port checker for the flash status poller
`default_nettype none
module flash_status_poller_sva
    import flash_poll_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // flash pins
    input wire logic [19:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ****
    // properties
    // ****
    property p_bus_okay; hreadyout && !hresp; endproperty
    property p_strobe_len; $fell(flash_ce_n) |-> !flash_ce_n [*2] ##1 flash_ce_n; endproperty
    property p_release_all; $rose(flash_ce_n) |-> flash_oe_n && flash_we_n; endproperty
    property p_we_in_ce; !flash_we_n |-> !flash_ce_n && flash_dq_oe; endproperty
    property p_no_fight; !flash_oe_n |-> !flash_dq_oe; endproperty
    property p_oe_we_apart; !flash_oe_n |-> flash_we_n; endproperty
    property p_hold; !flash_ce_n && !$fell(flash_ce_n) |-> $stable(flash_addr) && $stable(flash_dq_out); endproperty
    property p_unmapped; hsel && hready && htrans[1] && !hwrite && haddr == 8'h14 |=> hrdata == 32'h0; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
    a_strobe_len: assert property (p_strobe_len) else $error("chip enable width wrong");
    a_release_all: assert property (p_release_all) else $error("strobe left low at cycle end");
    a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside cycle");
    a_no_fight: assert property (p_no_fight) else $error("data driven during read");
    a_oe_we_apart: assert property (p_oe_we_apart) else $error("read and write strobes together");
    a_hold: assert property (p_hold) else $error("address or data moved in cycle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_write: cover property ($fell(flash_we_n));
    c_read: cover property ($fell(flash_oe_n));
    c_unmapped: cover property (hsel && hready && htrans[1] && haddr == 8'h14);
endmodule : flash_status_poller_sva
bind flash_status_poller flash_status_poller_sva flash_status_poller_sva_i (.sys_clk, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .flash_addr, .flash_dq_out, .flash_dq_oe,
    .flash_ce_n, .flash_oe_n, .flash_we_n);
`default_nettype wire

/* File: test/test_flash_status_poller.sv */
// self-checking bench for the flash status poller
`default_nettype none
module test_flash_status_poller
    import flash_poll_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [7:0] reads; logic fail; logic [1:0] res; logic tbit;} row_t;
    row_t rows [4] = '{'{8'h00, 1'b0, res_done, 1'b0}, '{8'h01, 1'b0, res_done, 1'b0},
        '{8'h06, 1'b0, res_done, 1'b0}, '{8'h03, 1'b1, res_fail, 1'b1}};
    logic sys_clk, sys_rst, hsel, hwrite, kick, fail_mode, hreadyout, hresp;
    logic [7:0] haddr, busy_reads, resets_seen, erases_seen, base;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_out, dq_wire;
    logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, rb_low;
    int n_mismatch = 0;
    int n_compared = 0;
    wire logic hready = hreadyout;
    // shared busy line with its pull-up
    wire logic rb_pin = rb_low ? 1'b0 : 1'b1;
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    flash_status_poller flash_status_poller_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_dq_in(dq_wire), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .ready_busy_n_output(rb_pin));
    flash_dev_model #(.win_cycles(300)) flash_dev_model_i (.sys_clk(sys_clk), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .dq_wire(dq_wire), .rb_low(rb_low), .kick(kick), .busy_reads(busy_reads),
        .fail_mode(fail_mode), .resets_seen(resets_seen), .erases_seen(erases_seen));
    // ****
    // tasks
    // ****
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk
    task wait_ready;
        int k;
        k = 0;
        @(posedge sys_clk);
        while (hready !== 1'b1 && k < 50)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 50)
        begin
            n_mismatch++;
            final_report;
        end
    endtask : wait_ready
    // one single transfer; read data lands in rd
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready;
        rd = hrdata;
    endtask : ahb
    // status polled until the busy flag drops, bounded
    task wait_idle;
        int k;
        k = 0;
        rd = 32'h2;
        while (rd[1] !== 1'b0 && k < 3000)
        begin
            ahb(1'b0, stat_off, 32'h0);
            k++;
        end
        if (k >= 3000)
        begin
            n_mismatch++;
            final_report;
        end
    endtask : wait_idle
    task kick_dev(input logic [7:0] n, input logic f);
        busy_reads <= n;
        fail_mode <= f;
        kick <= 1'b1;
        @(posedge sys_clk);
        kick <= 1'b0;
        base = resets_seen;
    endtask : kick_dev
    // ****
    // main sequence
    // ****
    initial
    begin
        sys_rst = 1'b1;
        {hsel, hwrite, kick, fail_mode, haddr, busy_reads, htrans, hwdata} = '0;
        hsize = 3'b010;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        ahb(1'b0, stat_off, 32'h0);
        chk("status at reset", 32'h0, {28'h0, rd[3:0]});
        ahb(1'b0, 8'h14, 32'h0);
        chk("unmapped read", 32'h0, rd);
        ahb(1'b1, addr_off, 32'h0002_0040);
        ahb(1'b0, addr_off, 32'h0);
        chk("address readback", 32'h0002_0040, {12'h000, rd[19:0]});
        foreach (rows[i])
        begin
            kick_dev(rows[i].reads, rows[i].fail);
            ahb(1'b1, ctrl_off, 32'h1);
            wait_idle;
            chk("poll result", {30'h0, rows[i].res}, {30'h0, rd[3:2]});
            chk("timeout bit", {31'h0, rows[i].tbit}, {31'h0, rd[5]});
            chk("reset writes", {24'h0, base + {7'h0, rows[i].fail}}, {24'h0, resets_seen});
            chk("busy pin", 32'h0, {31'h0, rd[4]});
        end
        // an order given while busy must be dropped
        kick_dev(8'hC8, 1'b0);
        ahb(1'b1, ctrl_off, 32'h1);
        ahb(1'b0, stat_off, 32'h0);
        chk("busy flag", 32'h1, {31'h0, rd[1]});
        chk("busy pin running", 32'h1, {31'h0, rd[4]});
        ahb(1'b1, ctrl_off, 32'h4);
        wait_idle;
        chk("order while busy", {24'h0, base}, {24'h0, resets_seen});
        ahb(1'b1, ctrl_off, 32'h4);
        wait_idle;
        chk("reset command", {24'h0, base + 8'h01}, {24'h0, resets_seen});
        // sector erase, then a poll that spans the acceptance window
        busy_reads <= 8'h04;
        ahb(1'b1, addr_off, 32'h0003_0000);
        ahb(1'b1, ctrl_off, 32'h2);
        wait_idle;
        chk("erase accepted", 32'h1, {24'h0, erases_seen});
        chk("window bit", 32'h0, {31'h0, rd[7]});
        ahb(1'b1, ctrl_off, 32'h1);
        wait_idle;
        chk("erase poll", {30'h0, res_done}, {30'h0, rd[3:2]});
        final_report;
    end
endmodule : test_flash_status_poller
`default_nettype wire
